// ===== common/dsa_pkg.sv
// Shared constants and carriers for the data-space access unit.
// Assumes a 16-bit byte-addressed data space and a 16-bit core data path.
`default_nettype none
package dsa_pkg;
    localparam int          EA_W          = 16;
    localparam int          DATA_W        = 16;
    localparam int          MEM_WORDS     = 8192;   // 16 Kbytes of implemented memory
    localparam int          MEM_AW        = 13;
    localparam logic [15:0] MEM_TOP       = 16'h3FFF;
    localparam logic [15:0] NEAR_TOP      = 16'h1FFF;
    localparam logic [15:0] SFR_TOP       = 16'h07FF;
    localparam int          SFR_BLK_SHIFT = 5;      // 32-byte blocks
    localparam int          SFR_BLKS      = 64;
    localparam int          EA_PSV_BIT    = 15;
    localparam int          NEAR_AW       = 13;
    localparam logic [15:0] PTR_STEP_BYTE = 16'h0001;
    localparam logic [15:0] PTR_STEP_WORD = 16'h0002;
    // Implemented 32-byte blocks of the register region, bit n covers n*32
    localparam logic [63:0] SFR_IMPL_MAP  = 64'h0C77_0000_03FF_FF7F;

    typedef enum logic [2:0]
    {
        MODE_INDIRECT = 3'h1,
        MODE_NEAR     = 3'h2,
        MODE_FULL     = 3'h4
    } addr_mode_e;

    typedef enum logic [2:0]
    {
        EXT_NONE = 3'h1,
        EXT_SIGN = 3'h2,
        EXT_ZERO = 3'h4
    } ext_op_e;

    typedef struct packed
    {
        logic        valid;
        logic        write;
        logic        byte_op;
        logic        post_inc;
        addr_mode_e  mode;
        logic [15:0] indirect_source_pointer;
        logic [15:0] direct_addr;
        logic [15:0] wdata;
    } acc_req_s;

    typedef struct packed
    {
        logic        valid;
        ext_op_e     op;
        logic [15:0] wreg;
    } ext_req_s;
endpackage : dsa_pkg
`default_nettype wire

// ===== core/data_space_access_align.sv
// Data-space access unit: address scaling, byte steering, alignment trap.
// Assumes core logic on clk issues one request at a time; no pin inputs.
// Notes on behaviour
// - Post-increment advances the pointer by one for bytes, two for words.
// - Byte read fetches the whole word; address bit 0 picks the byte.
// - Selected byte is delivered on the low eight data bits.
// - Two byte lanes, shared word decode, separate write strobes per lane.
// - Word access at an odd address raises an address error trap.
// - Read address error lets the instruction complete, then traps.
// - Write address error executes but suppresses the memory write, then traps.
// - Byte load into a working register changes only its low byte.
// - Sign-extend turns an 8-bit signed value into 16 bits.
// - Zero-extend clears the upper byte of a working register.
// - Memory-direct near access uses a 13-bit field, reaching 0000h-1FFFh.
// - Move instruction uses a 16-bit direct field for the whole space.
// - 0000h to 07FFh is decoded as the register region.
// - Unused addresses in the register region read as zero.
// - Register region implementation is tracked in 32-byte blocks.
// - Low byte sits at the even address, high byte at the odd one.
// - Addresses 4000h to 7FFFh, beyond 16 Kbytes of memory, read as zero.
// - Addresses are 16-bit byte addresses; top bit set is program visibility.
`timescale 1ns/1ps
`default_nettype none
module data_space_access_align
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire dsa_pkg::acc_req_s req,
    input  wire logic [15:0]      load_wreg,
    input  wire dsa_pkg::ext_req_s ext_req,
    input  wire logic [15:0]      psv_rdata,
    output logic                  rvalid,
    output logic [15:0]           rdata,
    output logic [15:0]           load_result,
    output logic [15:0]           next_pointer,
    output logic                  addr_error_trap,
    output logic                  sfr_sel,
    output logic                  psv_sel,
    output logic [15:0]           psv_addr,
    output logic                  ext_valid,
    output logic [15:0]           ext_result
);
    import dsa_pkg::*;

    logic [7:0] lane_lo [MEM_WORDS];
    logic [7:0] lane_hi [MEM_WORDS];

    logic [15:0] ea;
    logic        misaligned;
    logic        in_mem;
    logic        in_sfr;
    logic        in_psv;
    logic        sfr_impl;
    logic [12:0] widx;
    logic        we_lo;
    logic        we_hi;
    logic        rd_byte;
    logic        rd_hi_sel;
    logic        rd_zero;
    logic        rd_psv;
    logic [15:0] rd_wreg;
    logic        rd_req;
    logic        pend_trap;
    logic        pend_late;

    function automatic logic blk_impl(input logic [15:0] a);
        blk_impl = SFR_IMPL_MAP[a[SFR_BLK_SHIFT +: 6]];
    endfunction : blk_impl

    // Effective address selection
    always_comb
    begin
        unique case (req.mode)
            MODE_NEAR:     ea = {3'h0, req.direct_addr[NEAR_AW-1:0]};
            MODE_FULL:     ea = req.direct_addr;
            default:       ea = req.indirect_source_pointer;
        endcase
    end

    assign misaligned = req.valid && !req.byte_op && ea[0];
    assign in_psv     = ea[EA_PSV_BIT];
    assign in_mem     = !in_psv && (ea <= MEM_TOP);
    assign in_sfr     = ea <= SFR_TOP;
    assign sfr_impl   = blk_impl(ea);
    assign widx       = ea[13:1];
    // Strobes gated by alignment so a bad word write never lands
    assign we_lo = req.valid && req.write && !misaligned && in_mem
                   && (!req.byte_op || !ea[0]);
    assign we_hi = req.valid && req.write && !misaligned && in_mem
                   && (!req.byte_op || ea[0]);

    // Byte lanes with shared word decode
    always_ff @(posedge clk)
    begin
        if (we_lo)
            lane_lo[widx] <= req.wdata[7:0];
        if (we_hi)
            lane_hi[widx] <= req.byte_op ? req.wdata[7:0] : req.wdata[15:8];
    end

    // Whole word is fetched; only the selection differs for bytes
    logic [15:0] word_q;
    always_ff @(posedge clk)
        word_q <= {lane_hi[widx], lane_lo[widx]};

    // First stage: remember what the read asked for
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_req    <= 1'b0;
            rd_byte   <= 1'b0;
            rd_hi_sel <= 1'b0;
            rd_zero   <= 1'b0;
            rd_psv    <= 1'b0;
            rd_wreg   <= 16'h0000;
        end
        else
        begin
            rd_req    <= req.valid && !req.write;
            rd_byte   <= req.byte_op;
            rd_hi_sel <= ea[0];
            rd_zero   <= !in_psv && (!in_mem || (in_sfr && !sfr_impl));
            rd_psv    <= in_psv;
            rd_wreg   <= load_wreg;
        end
    end

    logic [15:0] word_sel;
    logic [7:0]  byte_sel;
    always_comb
    begin
        word_sel = rd_zero ? 16'h0000 : (rd_psv ? psv_rdata : word_q);
        byte_sel = rd_hi_sel ? word_sel[15:8] : word_sel[7:0];
    end

    // Second stage: answer leaves from flops; program-space data lands here
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rvalid      <= 1'b0;
            rdata       <= 16'h0000;
            load_result <= 16'h0000;
        end
        else
        begin
            rvalid      <= rd_req;
            rdata       <= rd_byte ? {8'h00, byte_sel} : word_sel;
            load_result <= rd_byte ? {rd_wreg[15:8], byte_sel} : word_sel;
        end
    end

    // Pointer post-modify
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            next_pointer <= 16'h0000;
        else if (req.valid && req.post_inc && req.mode == MODE_INDIRECT)
            next_pointer <= req.indirect_source_pointer
                            + (req.byte_op ? PTR_STEP_BYTE : PTR_STEP_WORD);
        else if (req.valid)
            next_pointer <= req.indirect_source_pointer;
    end

    // Trap trails the read answer by a cycle so the instruction completes first
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pend_trap       <= 1'b0;
            pend_late       <= 1'b0;
            addr_error_trap <= 1'b0;
        end
        else
        begin
            pend_trap       <= misaligned;
            pend_late       <= pend_trap;
            addr_error_trap <= pend_late;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sfr_sel  <= 1'b0;
            psv_sel  <= 1'b0;
            psv_addr <= 16'h0000;
        end
        else
        begin
            sfr_sel  <= req.valid && in_sfr && sfr_impl;
            psv_sel  <= req.valid && in_psv;
            psv_addr <= ea;
        end
    end

    // Extend operations on a working register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_valid  <= 1'b0;
            ext_result <= 16'h0000;
        end
        else
        begin
            ext_valid <= ext_req.valid;
            unique case (ext_req.op)
                EXT_SIGN: ext_result <= {{8{ext_req.wreg[7]}}, ext_req.wreg[7:0]};
                EXT_ZERO: ext_result <= {8'h00, ext_req.wreg[7:0]};
                default:  ext_result <= ext_req.wreg;
            endcase
        end
    end

    // Read answer two cycles after the request, trap one cycle later still
    sequence read_answer_s;
        ##2 rvalid;
    endsequence
    sequence trap_after_s;
        ##3 addr_error_trap;
    endsequence

    // Alignment trap
    odd_word_traps_a: assert property (@(posedge clk) disable iff (!rstn)
        misaligned |-> trap_after_s)
        else $error("odd word access did not trap");
    trap_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        !misaligned |-> ##3 !addr_error_trap)
        else $error("trap without odd word access");
    no_bad_write_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.write && misaligned)
        |=> {lane_hi[$past(widx)], lane_lo[$past(widx)]}
            === $past({lane_hi[widx], lane_lo[widx]}))
        else $error("misaligned word write changed memory");
    read_completes_a: assert property (@(posedge clk) disable iff (!rstn)
        (misaligned && !req.write) |-> read_answer_s ##1 addr_error_trap)
        else $error("read did not complete before trap");

    // Read answer
    read_latency_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && !req.write) |-> read_answer_s)
        else $error("read answer late or missing");
    read_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        !(req.valid && !req.write) |-> ##2 !rvalid)
        else $error("read answer without a read");
    byte_select_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && !req.write && req.byte_op && in_mem && !in_sfr)
        |-> ##2 rdata[7:0] == ($past(ea[0], 2) ? $past(word_q[15:8]) : $past(word_q[7:0])))
        else $error("wrong byte of the word selected");
    byte_low_lane_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && !req.write && req.byte_op) |-> ##2 rdata[15:8] == 8'h00)
        else $error("byte read not on low lane");
    load_keeps_msb_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && !req.write && req.byte_op)
        |-> ##2 load_result[15:8] == $past(load_wreg[15:8], 2))
        else $error("byte load changed upper byte");

    // Pointer post-modify
    ptr_step_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.post_inc && req.mode == MODE_INDIRECT)
        |=> next_pointer == $past(req.indirect_source_pointer)
            + ($past(req.byte_op) ? PTR_STEP_BYTE : PTR_STEP_WORD))
        else $error("pointer step wrong");
    ptr_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && !(req.post_inc && req.mode == MODE_INDIRECT))
        |=> next_pointer == $past(req.indirect_source_pointer))
        else $error("pointer moved without post-increment");

    // Extend operations
    sign_extend_a: assert property (@(posedge clk) disable iff (!rstn)
        (ext_req.valid && ext_req.op == EXT_SIGN)
        |=> ext_result == {{8{$past(ext_req.wreg[7])}}, $past(ext_req.wreg[7:0])})
        else $error("sign extend wrong");
    zero_extend_a: assert property (@(posedge clk) disable iff (!rstn)
        (ext_req.valid && ext_req.op == EXT_ZERO)
        |=> ext_result == {8'h00, $past(ext_req.wreg[7:0])})
        else $error("zero extend wrong");
    ext_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        ext_req.valid |=> ext_valid)
        else $error("extend result not flagged");

    // Address windows and byte write strobes
    out_of_range_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && !req.write && !in_psv && !in_mem) |-> ##2 rdata == 16'h0000)
        else $error("out of range read not zero");
    sfr_unused_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && !req.write && in_sfr && !sfr_impl) |-> ##2 rdata == 16'h0000)
        else $error("unused register block read not zero");
    sfr_select_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && in_sfr && sfr_impl) |=> sfr_sel)
        else $error("implemented register block not selected");
    psv_forward_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && in_psv) |=> (psv_sel && psv_addr == $past(ea)))
        else $error("program window request not forwarded");
    near_field_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.mode == MODE_NEAR)
        |=> psv_addr == {3'h0, $past(req.direct_addr[NEAR_AW-1:0])})
        else $error("near address not taken from the short field");
    full_field_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.mode == MODE_FULL) |=> psv_addr == $past(req.direct_addr))
        else $error("full address not taken from the long field");
    byte_strobe_a: assert property (@(posedge clk) disable iff (!rstn)
        (req.valid && req.byte_op) |-> !(we_lo && we_hi))
        else $error("byte write hit both lanes");
endmodule : data_space_access_align
`default_nettype wire

// ===== test/psv_model.sv
// Program-space side of the visibility window, answering word reads.
// Assumes psv_sel/psv_addr are registered; data is wanted in that cycle.
`timescale 1ns/1ps
`default_nettype none
module psv_model
(
    input  wire logic        clk,
    input  wire logic        psv_sel,
    input  wire logic [15:0] psv_addr,
    output logic [15:0]      psv_rdata
);
    logic [15:0] junk;

    // Idle data churns so a stale capture cannot pass by luck
    always @(posedge clk)
    begin
        junk <= ~junk + 16'h0001;
    end

    initial junk = 16'h0F0F;

    assign psv_rdata = psv_sel ? {psv_addr[7:0], psv_addr[15:8]} : junk;
endmodule : psv_model
`default_nettype wire

// ===== test/tb_data_space_access_align.sv
// Self-checking bench for the data-space access unit.
// Assumes fixed latencies: selects +1, read data +2, trap +3 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_data_space_access_align;
    import dsa_pkg::*;
    logic        clk;
    logic        rstn;
    acc_req_s    req;
    ext_req_s    ext_req;
    logic [15:0] load_wreg, psv_rdata, rdata, load_result, next_pointer;
    logic [15:0] psv_addr, ext_result;
    logic        rvalid, addr_error_trap, sfr_sel, psv_sel, ext_valid;
    logic [15:0] r_q, lr_q, np_q;
    logic        v_q, tr_q, sf_q, ps_q;
    int          err_total, checks_done;

    data_space_access_align i_data_space_access_align (.clk(clk), .rstn(rstn),
        .req(req), .load_wreg(load_wreg), .ext_req(ext_req), .psv_rdata(psv_rdata),
        .rvalid(rvalid), .rdata(rdata), .load_result(load_result),
        .next_pointer(next_pointer), .addr_error_trap(addr_error_trap),
        .sfr_sel(sfr_sel), .psv_sel(psv_sel), .psv_addr(psv_addr),
        .ext_valid(ext_valid), .ext_result(ext_result));
    psv_model i_psv_model (.clk(clk), .psv_sel(psv_sel), .psv_addr(psv_addr),
        .psv_rdata(psv_rdata));

    always #2 clk = ~clk;

    task automatic give_verdict;
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // One request; captures the answer cycle and the trap cycle
    task automatic acc(input logic w, b, pi, input addr_mode_e m,
                       input logic [15:0] p, d, wd);
        @(posedge clk);
        req <= '{1'b1, w, b, pi, m, p, d, wd};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        {np_q, sf_q, ps_q} = {next_pointer, sfr_sel, psv_sel};
        @(posedge clk);
        #1;
        {v_q, r_q, lr_q} = {rvalid, rdata, load_result};
        @(posedge clk);
        #1;
        tr_q = addr_error_trap;
    endtask : acc

    task automatic ext(input ext_op_e op, input logic [15:0] w, exp);
        @(posedge clk);
        ext_req <= '{1'b1, op, w};
        @(posedge clk);
        ext_req.valid <= 1'b0;
        #1;
        `CHK(ext_valid, 1'b1)
        `CHK(ext_result, exp)
    endtask : ext

    task automatic lanes_and_steps;
        acc(1, 0, 1, MODE_INDIRECT, 16'h1000, 16'h0, 16'hA55A);
        `CHK(np_q, 16'h1002)
        acc(1, 1, 1, MODE_INDIRECT, 16'h1001, 16'h0, 16'h00C3);
        `CHK(np_q, 16'h1002)
        acc(0, 0, 0, MODE_INDIRECT, 16'h1000, 16'h0, 16'h0);
        `CHK(r_q, 16'hC35A)
        `CHK(np_q, 16'h1000)
        `CHK(tr_q, 1'b0)
        load_wreg <= 16'h7700;
        acc(0, 1, 0, MODE_FULL, 16'h0, 16'h1001, 16'h0);
        `CHK(r_q, 16'h00C3)
        `CHK(lr_q, 16'h77C3)
        acc(0, 1, 0, MODE_NEAR, 16'h0, 16'hF000, 16'h0);
        `CHK(r_q, 16'h005A)
    endtask : lanes_and_steps

    task automatic misaligned;
        acc(1, 0, 0, MODE_INDIRECT, 16'h1001, 16'h0, 16'hFFFF);
        `CHK(tr_q, 1'b1)
        `CHK(v_q, 1'b0)
        acc(0, 0, 0, MODE_INDIRECT, 16'h1003, 16'h0, 16'h0);
        `CHK(v_q, 1'b1)
        `CHK(tr_q, 1'b1)
        acc(0, 0, 0, MODE_INDIRECT, 16'h1000, 16'h0, 16'h0);
        `CHK(r_q, 16'hC35A)
    endtask : misaligned

    task automatic windows;
        acc(0, 0, 0, MODE_FULL, 16'h0, 16'h4000, 16'h0);
        `CHK(r_q, 16'h0000)
        acc(0, 0, 0, MODE_NEAR, 16'h0, 16'h07E0, 16'h0);
        `CHK(r_q, 16'h0000)
        `CHK(sf_q, 1'b0)
        acc(0, 0, 0, MODE_NEAR, 16'h0, 16'h0002, 16'h0);
        `CHK(sf_q, 1'b1)
        acc(0, 0, 0, MODE_INDIRECT, 16'h8124, 16'h0, 16'h0);
        `CHK(ps_q, 1'b1)
        `CHK(r_q, 16'h2481)
    endtask : windows

    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        req = '0;
        ext_req = '0;
        load_wreg = 16'h0000;
        err_total = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        lanes_and_steps();
        misaligned();
        windows();
        ext(EXT_SIGN, 16'h1280, 16'hFF80);
        ext(EXT_SIGN, 16'h127F, 16'h007F);
        ext(EXT_ZERO, 16'h12F0, 16'h00F0);
        ext(EXT_NONE, 16'h1280, 16'h1280);
        give_verdict();
    end

    // Hang guard
    initial
    begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule : tb_data_space_access_align
`default_nettype wire
